//--- hw/fault_supervisor_pkg.sv
// Package: constants and carrier types for the buck output fault supervisor
package fault_supervisor_pkg;

	// Internal clock: 128 cycles last 0.32 ms
	localparam int CLOCK_MHZ = 200;
	localparam int INT_CLOCK_RUN_CYCLES = 128;
	localparam int INT_CLOCK_RUN_US = 320;
	localparam int INT_TICK_NS = (INT_CLOCK_RUN_US * 1000) / INT_CLOCK_RUN_CYCLES;
	localparam int INT_TICK_CYCLES = (INT_TICK_NS * CLOCK_MHZ) / 1000;
	localparam int TICK_WIDTH = 10;

	// Consecutive internal cycles needed to latch a fault
	localparam int QUALIFY_TICKS = 4;
	localparam int QUALIFY_WIDTH = 3;

	// Status / mask bit positions
	localparam int STAT_OV_BIT = 0;
	localparam int STAT_UV_BIT = 1;
	localparam int STAT_DISCH_BIT = 2;
	localparam int STAT_BOOST_BIT = 3;
	localparam int STAT_WIDTH = 4;

	// Register offsets
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_MASK = 4'h1;
	localparam logic [3:0] ADDR_STATE = 4'h2;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic [7:0] ZERO_READ = 8'h00;

	// Output comparator results from the regulated output
	typedef struct packed {
		logic aboveOvershoot;
		logic aboveOverVoltage;
		logic belowBoost;
		logic belowUnderVoltage;
		logic atNominal;
	} comparator_type;

	// Supply and mode inputs
	typedef struct packed {
		logic regulatorEnable;
		logic analogSupplyGood;
		logic conversionRailGood;
		logic standbyState;
		logic forcedSwitchingSelect;
	} supply_type;

	// Gate overrides towards the drivers
	typedef struct packed {
		logic highSideForceOff;
		logic lowSideForceOn;
		logic lowSideForceOff;
		logic maxFrequency;
	} gate_type;

	typedef enum logic [3:0] {
		RUN = 4'h1,
		DISCHARGE = 4'h2,
		OV_LATCHED = 4'h4,
		UV_LATCHED = 4'h8
	} mode_type;

	// Register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_type;

endpackage : fault_supervisor_pkg

//--- hw/internal_tick.sv
// Internal fault clock tick generator
`timescale 1ns/1ps
module internal_tick
	import fault_supervisor_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic run,
	output logic tick
);

	typedef struct packed {
		logic [TICK_WIDTH-1:0] count;
		logic tick;
	} tick_state_type;

	tick_state_type state_r;
	tick_state_type state_nxt;

	// Restart while halted so the first tick after enable is a full period
	always_comb begin
		state_nxt = state_r;
		state_nxt.tick = 1'b0;
		if (!run) begin
			state_nxt.count = '0;
		end else if (state_r.count == TICK_WIDTH'(INT_TICK_CYCLES - 1)) begin
			state_nxt.count = '0;
			state_nxt.tick = 1'b1;
		end else begin
			state_nxt.count = state_r.count + TICK_WIDTH'(1);
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign tick = state_r.tick;

	AST_TICK_SPACING: assert property (@(posedge clock) disable iff (!rst_b) // [RULE11]
		tick |=> !tick [*2]) else $error("Tick pulses too close");

endmodule : internal_tick

//--- hw/fault_qualifier.sv
// Consecutive-tick fault qualifier with restart on any gap
`timescale 1ns/1ps
module fault_qualifier
	import fault_supervisor_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic tick,
	input wire logic condition,
	output logic qualified
);

	typedef struct packed {
		logic [QUALIFY_WIDTH-1:0] count;
		logic qualified;
	} qual_state_type;

	qual_state_type state_r;
	qual_state_type state_nxt;

	always_comb begin
		state_nxt = state_r;
		state_nxt.qualified = 1'b0;
		if (clear || !condition) begin
			state_nxt.count = '0; // [RULE12]
		end else if (tick) begin
			if (state_r.count == QUALIFY_WIDTH'(QUALIFY_TICKS - 1)) begin
				state_nxt.qualified = 1'b1;
				state_nxt.count = '0;
			end else begin
				state_nxt.count = state_r.count + QUALIFY_WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign qualified = state_r.qualified;

	AST_GAP_RESTARTS: assert property (@(posedge clock) disable iff (!rst_b) // [RULE12]
		!condition |=> state_r.count == '0) else $error("Count not restarted");

endmodule : fault_qualifier

//--- hw/buck_output_fault_supervisor.sv
// Fault supervisor for the memory-supply buck converter output
// Functional notes
// [RULE1] Between 106% and 130%: high side off, low side on to discharge.
// [RULE2] Back at nominal after overshoot discharge: resume ordinary switching.
// [RULE3] Above 130% for 4 internal cycles: latch overvoltage, both switches off.
// [RULE4] Overvoltage latch holds until enable, analog supply or input rail toggles.
// [RULE5] Standby power-saving below 94%: raise switching to maximum frequency.
// [RULE6] Back at nominal after boost: resume reduced-frequency power saving.
// [RULE7] Below 65% for 4 internal cycles in either state: latch undervoltage.
// [RULE8] Undervoltage latch-off: no active discharge, both switches off.
// [RULE9] Undervoltage latch clears only when enable, analog supply or input rail cycles.
// [RULE10] Outside system holds forced-switching select high for power saving.
// [RULE11] Internal clock: 128 cycles last 0.32 ms.
// [RULE12] Qualification counters restart whenever the condition disappears.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module buck_output_fault_supervisor
	import fault_supervisor_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input comparator_type compare,
	input supply_type supply,
	input bus_type bus,
	output logic [7:0] readData,
	output gate_type gate,
	output logic faultLatched,
	output logic irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		mode_type mode;
		logic boost;
		gate_type gate;
		logic [STAT_WIDTH-1:0] status;
		logic [STAT_WIDTH-1:0] mask;
		logic [7:0] readData;
	} sup_state_type;

	sup_state_type state_r;
	sup_state_type state_nxt;

	logic powered;
	logic powerSaving;
	logic tick;
	logic ovQualified;
	logic uvQualified;
	logic clearQual;

	// Any dropped enable or supply is the only latch reset path apart from rst_b
	assign powered = supply.regulatorEnable && supply.analogSupplyGood && supply.conversionRailGood;
	assign powerSaving = supply.standbyState && supply.forcedSwitchingSelect; // [RULE10]
	assign clearQual = !powered || state_r.mode == OV_LATCHED || state_r.mode == UV_LATCHED;

	// ----------------------------------------------------------------
	// Qualification
	// ----------------------------------------------------------------
	internal_tick tickGen (
		.clock(clock),
		.rst_b(rst_b),
		.run(powered),
		.tick(tick) // [RULE11]
	);

	fault_qualifier ovQual (
		.clock(clock),
		.rst_b(rst_b),
		.clear(clearQual),
		.tick(tick),
		.condition(compare.aboveOverVoltage),
		.qualified(ovQualified)
	);

	fault_qualifier uvQual (
		.clock(clock),
		.rst_b(rst_b),
		.clear(clearQual),
		.tick(tick),
		.condition(compare.belowUnderVoltage),
		.qualified(uvQualified)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		state_nxt.readData = ZERO_READ;
		if (!powered) begin
			state_nxt.mode = RUN; // [RULE4] [RULE9]
			state_nxt.boost = 1'b0;
		end else begin
			case (state_r.mode)
				RUN: begin
					if (ovQualified) begin
						state_nxt.mode = OV_LATCHED; // [RULE3]
					end else if (uvQualified) begin
						state_nxt.mode = UV_LATCHED; // [RULE7]
					end else if (compare.aboveOvershoot && !compare.aboveOverVoltage) begin
						state_nxt.mode = DISCHARGE; // [RULE1]
					end
				end
				DISCHARGE: begin
					if (ovQualified) begin
						state_nxt.mode = OV_LATCHED; // [RULE3]
					end else if (compare.atNominal) begin
						state_nxt.mode = RUN; // [RULE2]
					end
				end
				OV_LATCHED: state_nxt.mode = OV_LATCHED; // [RULE4]
				UV_LATCHED: state_nxt.mode = UV_LATCHED; // [RULE9]
				default: state_nxt.mode = RUN;
			endcase
			// Frequency boost only matters in standby power saving
			if (!powerSaving) begin
				state_nxt.boost = 1'b0;
			end else if (compare.belowBoost) begin
				state_nxt.boost = 1'b1; // [RULE5]
			end else if (compare.atNominal) begin
				state_nxt.boost = 1'b0; // [RULE6]
			end
		end

		// Gate override from the mode being entered
		state_nxt.gate = '0;
		case (state_nxt.mode)
			RUN: state_nxt.gate.maxFrequency = state_nxt.boost;
			DISCHARGE: begin
				state_nxt.gate.highSideForceOff = 1'b1; // [RULE1]
				state_nxt.gate.lowSideForceOn = 1'b1;
			end
			OV_LATCHED: begin
				state_nxt.gate.highSideForceOff = 1'b1; // [RULE3]
				state_nxt.gate.lowSideForceOff = 1'b1;
			end
			UV_LATCHED: begin
				state_nxt.gate.highSideForceOff = 1'b1; // [RULE8]
				state_nxt.gate.lowSideForceOff = 1'b1;
			end
			default: state_nxt.gate = '0;
		endcase

		// Register reads; reading status clears it, new events win
		if (bus.rd) begin
			case (bus.addr)
				ADDR_STATUS: begin
					state_nxt.readData = 8'(state_r.status);
					state_nxt.status = '0;
				end
				ADDR_MASK: state_nxt.readData = 8'(state_r.mask);
				ADDR_STATE: state_nxt.readData = 8'(state_r.mode);
				default: state_nxt.readData = ZERO_READ;
			endcase
		end
		if (bus.wr && bus.addr == ADDR_MASK) begin
			state_nxt.mask = bus.wdata[STAT_WIDTH-1:0];
		end
		if (state_nxt.mode == OV_LATCHED && state_r.mode != OV_LATCHED) begin
			state_nxt.status[STAT_OV_BIT] = 1'b1;
		end
		if (state_nxt.mode == UV_LATCHED && state_r.mode != UV_LATCHED) begin
			state_nxt.status[STAT_UV_BIT] = 1'b1;
		end
		if (state_nxt.mode == DISCHARGE && state_r.mode != DISCHARGE) begin
			state_nxt.status[STAT_DISCH_BIT] = 1'b1;
		end
		if (state_nxt.boost && !state_r.boost) begin
			state_nxt.status[STAT_BOOST_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= '{mode: RUN, boost: 1'b0, gate: '0, status: '0, mask: MASK_RESET, readData: ZERO_READ};
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign gate = state_r.gate;
	assign readData = state_r.readData;
	assign faultLatched = state_r.mode == OV_LATCHED || state_r.mode == UV_LATCHED;
	assign irq = |(state_r.status & state_r.mask);

	// ----------------------------------------------------------------
	// Checks: discharge and overvoltage
	// ----------------------------------------------------------------
	AST_DISCHARGE_ENTRY: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
		powered && state_r.mode == RUN && !ovQualified && !uvQualified
		&& compare.aboveOvershoot && !compare.aboveOverVoltage |=> state_r.mode == DISCHARGE)
		else $error("Discharge not entered");

	AST_DISCHARGE_STATUS: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
		powered && state_r.mode == RUN && !ovQualified && !uvQualified
		&& compare.aboveOvershoot && !compare.aboveOverVoltage |=> state_r.status[STAT_DISCH_BIT])
		else $error("Discharge event not flagged");

	AST_DISCHARGE_GATES: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
		state_r.mode == DISCHARGE
		|-> gate.highSideForceOff && gate.lowSideForceOn && !gate.lowSideForceOff)
		else $error("Discharge gates wrong");

	// Past the overvoltage point run does not enter discharge; a discharge already running goes on until the latch
	AST_NO_DISCHARGE_ABOVE: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
		powered && state_r.mode == RUN && !ovQualified && !uvQualified
		&& compare.aboveOverVoltage |=> state_r.mode == RUN)
		else $error("Discharge above overvoltage point");

	AST_RESUME_NOMINAL: assert property (@(posedge clock) disable iff (!rst_b) // [RULE2]
		state_r.mode == DISCHARGE && powered && compare.atNominal && !ovQualified
		|=> state_r.mode == RUN && !gate.lowSideForceOn)
		else $error("No resume after discharge");

	AST_RUN_GATES: assert property (@(posedge clock) disable iff (!rst_b) // [RULE2]
		state_r.mode == RUN
		|-> !gate.highSideForceOff && !gate.lowSideForceOn && !gate.lowSideForceOff)
		else $error("Override left on in run");

	AST_OV_LATCH: assert property (@(posedge clock) disable iff (!rst_b) // [RULE3]
		powered && ovQualified && state_r.mode inside {RUN, DISCHARGE}
		|=> state_r.mode == OV_LATCHED && gate.highSideForceOff && gate.lowSideForceOff)
		else $error("Overvoltage not latched");

	AST_OV_STATUS: assert property (@(posedge clock) disable iff (!rst_b) // [RULE3]
		powered && ovQualified && state_r.mode inside {RUN, DISCHARGE}
		|=> state_r.status[STAT_OV_BIT])
		else $error("Overvoltage event not flagged");

	AST_OV_GATES: assert property (@(posedge clock) disable iff (!rst_b) // [RULE3]
		state_r.mode == OV_LATCHED
		|-> gate.highSideForceOff && gate.lowSideForceOff && !gate.lowSideForceOn && !gate.maxFrequency)
		else $error("Overvoltage gates wrong");

	AST_OV_HOLD: assert property (@(posedge clock) disable iff (!rst_b) // [RULE4]
		state_r.mode == OV_LATCHED && powered
		|=> state_r.mode == OV_LATCHED)
		else $error("Overvoltage latch lost");

	AST_OV_CLEAR: assert property (@(posedge clock) disable iff (!rst_b) // [RULE4]
		state_r.mode == OV_LATCHED && !powered
		|=> state_r.mode == RUN && gate == '0)
		else $error("Overvoltage latch not cleared");

	AST_QUAL_CLEARED: assert property (@(posedge clock) disable iff (!rst_b) // [RULE4]
		!powered
		|=> !ovQualified && !uvQualified)
		else $error("Qualifier survived power drop");

	// ----------------------------------------------------------------
	// Checks: undervoltage
	// ----------------------------------------------------------------
	AST_UV_LATCH: assert property (@(posedge clock) disable iff (!rst_b) // [RULE7]
		powered && uvQualified && !ovQualified && state_r.mode == RUN
		|=> state_r.mode == UV_LATCHED)
		else $error("Undervoltage not latched");

	AST_UV_STATUS: assert property (@(posedge clock) disable iff (!rst_b) // [RULE7]
		powered && uvQualified && !ovQualified && state_r.mode == RUN
		|=> state_r.status[STAT_UV_BIT])
		else $error("Undervoltage event not flagged");

	AST_UV_GATES: assert property (@(posedge clock) disable iff (!rst_b) // [RULE7]
		state_r.mode == UV_LATCHED
		|-> gate.highSideForceOff && gate.lowSideForceOff && !gate.maxFrequency)
		else $error("Undervoltage gates wrong");

	// The low side must stay off here, or the output would be pulled below ground level
	AST_UV_NO_DISCHARGE: assert property (@(posedge clock) disable iff (!rst_b) // [RULE8]
		state_r.mode == UV_LATCHED
		|-> !gate.lowSideForceOn && gate.lowSideForceOff)
		else $error("Active discharge during undervoltage");

	AST_UV_HOLD: assert property (@(posedge clock) disable iff (!rst_b) // [RULE9]
		state_r.mode == UV_LATCHED && powered
		|=> state_r.mode == UV_LATCHED)
		else $error("Undervoltage latch lost");

	AST_UV_CLEAR: assert property (@(posedge clock) disable iff (!rst_b) // [RULE9]
		state_r.mode == UV_LATCHED && !powered
		|=> state_r.mode == RUN)
		else $error("Undervoltage latch not cleared");

	// ----------------------------------------------------------------
	// Checks: frequency boost
	// ----------------------------------------------------------------
	// Boost tracking runs in every mode; it only reaches the gates while running
	AST_BOOST: assert property (@(posedge clock) disable iff (!rst_b) // [RULE5]
		powered && powerSaving && compare.belowBoost
		|=> state_r.boost)
		else $error("No frequency boost");

	AST_BOOST_STATUS: assert property (@(posedge clock) disable iff (!rst_b) // [RULE5]
		powered && powerSaving && compare.belowBoost && !state_r.boost
		|=> state_r.status[STAT_BOOST_BIT])
		else $error("Boost event not flagged");

	AST_BOOST_GATE: assert property (@(posedge clock) disable iff (!rst_b) // [RULE5]
		state_r.mode == RUN
		|-> gate.maxFrequency == state_r.boost)
		else $error("Boost not on the gates");

	AST_BOOST_END: assert property (@(posedge clock) disable iff (!rst_b) // [RULE6]
		powered && powerSaving && !compare.belowBoost && compare.atNominal
		|=> !state_r.boost)
		else $error("Boost not released");

	AST_BOOST_NEEDS_SAVING: assert property (@(posedge clock) disable iff (!rst_b) // [RULE5]
		!powerSaving
		|=> !state_r.boost)
		else $error("Boost outside power saving");

	// ----------------------------------------------------------------
	// Checks: register bus and interrupt
	// ----------------------------------------------------------------
	AST_READ_ONE_CYCLE: assert property (@(posedge clock) disable iff (!rst_b)
		!bus.rd
		|=> readData == ZERO_READ)
		else $error("Read data held too long");

	// Standby saving is left out: a boost entry may set a bit in the same cycle
	AST_STATUS_READ_CLEARS: assert property (@(posedge clock) disable iff (!rst_b)
		bus.rd && bus.addr == ADDR_STATUS && powered && !powerSaving
		&& state_r.mode inside {OV_LATCHED, UV_LATCHED} |=> state_r.status == '0)
		else $error("Status not cleared by read");

	AST_IRQ: assert property (@(posedge clock) disable iff (!rst_b)
		powered && ovQualified && state_r.mode inside {RUN, DISCHARGE} && state_r.mask[STAT_OV_BIT]
		&& !(bus.wr && bus.addr == ADDR_MASK) |=> irq)
		else $error("Interrupt not raised");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	COV_DISCHARGE: cover property (@(posedge clock) disable iff (!rst_b)
		state_r.mode == DISCHARGE ##1 state_r.mode == RUN);
	COV_OV: cover property (@(posedge clock) disable iff (!rst_b) state_r.mode == OV_LATCHED);
	COV_UV: cover property (@(posedge clock) disable iff (!rst_b) state_r.mode == UV_LATCHED);
	COV_STANDBY_UV: cover property (@(posedge clock) disable iff (!rst_b) state_r.mode == UV_LATCHED && supply.standbyState);
	COV_BOOST: cover property (@(posedge clock) disable iff (!rst_b) state_r.boost ##1 !state_r.boost);

endmodule : buck_output_fault_supervisor

//--- verification/output_stage_model.sv
// Behavioural output stage: regulated output level and its window comparators
`timescale 1ns/1ps
module output_stage_model
	import fault_supervisor_pkg::*;
(
	input wire logic clock,
	input wire logic load,
	input wire logic [7:0] target,
	input gate_type gate,
	output comparator_type compare
);
	// Output level in percent of nominal
	logic [7:0] levelPct_r = 8'h64;

	// --------------------------------------------------------------
	// Output level
	// --------------------------------------------------------------
	// Only the low-side override pulls the level down; with both switches off it just sits,
	// as a light load would leave it over this short run
	always @(posedge clock) begin
		if (load) begin
			levelPct_r <= target;
		end else if (gate.lowSideForceOn && levelPct_r > 8'h64) begin
			levelPct_r <= levelPct_r - 8'h01;
		end
	end

	assign compare.aboveOvershoot = levelPct_r > 8'h6A;
	assign compare.aboveOverVoltage = levelPct_r > 8'h82;
	assign compare.belowBoost = levelPct_r < 8'h5E;
	assign compare.belowUnderVoltage = levelPct_r < 8'h41;
	assign compare.atNominal = levelPct_r == 8'h64;
endmodule : output_stage_model

//--- verification/tb_top.sv
// Self-checking testbench for the buck output fault supervisor
`timescale 1ns/1ps
module tb_top;
	import fault_supervisor_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic load = 1'b0;
	logic [7:0] target = 8'h64;
	supply_type supply = 5'h1C;
	bus_type bus = '0;
	comparator_type compare;
	gate_type gate;
	logic [7:0] readData;
	logic faultLatched;
	logic irq;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	gate_type gateQ[$];
	logic [7:0] readQ[$];
	gate_type gatePrev = '0;
	logic rdLast = 1'b0;

	always #2.5 clock = ~clock;

	output_stage_model stage_u (.clock(clock), .load(load), .target(target), .gate(gate), .compare(compare));
	buck_output_fault_supervisor dut_u (.clock(clock), .rst_b(rst_b), .compare(compare), .supply(supply),
		.bus(bus), .readData(readData), .gate(gate), .faultLatched(faultLatched), .irq(irq));

	// --------------------------------------------------------------
	// Compare and report
	// --------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cmpGate(input gate_type exp, input gate_type seen);
		check("gate", {4'h0, exp}, {4'h0, seen});
	endtask : cmpGate

	task automatic cmpRead(input logic [7:0] exp, input logic [7:0] seen);
		check("readData", exp, seen);
	endtask : cmpRead

	task automatic cmpFlag(input string what, input logic exp, input logic seen);
		check(what, {7'h00, exp}, {7'h00, seen});
	endtask : cmpFlag

	task automatic print_verdict();
		$display("Checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	// --------------------------------------------------------------
	// Result watcher: every gate change and read answer takes the oldest note
	// --------------------------------------------------------------
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			print_verdict();
		end
		if (rdLast) begin
			if (readQ.size() != 0) begin
				cmpRead(readQ.pop_front(), readData);
			end else begin
				cmpRead('x, readData);
			end
		end
		rdLast = bus.rd;
		if (gate !== gatePrev) begin
			if (gateQ.size() != 0) begin
				cmpGate(gateQ.pop_front(), gate);
			end else begin
				cmpGate('x, gate);
			end
			gatePrev = gate;
		end
	end

	// --------------------------------------------------------------
	// Drivers
	// --------------------------------------------------------------
	task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask : regWrite

	task automatic regRead(input logic [3:0] a, input logic [7:0] exp);
		readQ.push_back(exp);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'($urandom), wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
	endtask : regRead

	task automatic setLevel(input logic [7:0] pct);
		@(posedge clock);
		load <= 1'b1;
		target <= pct;
		@(posedge clock);
		load <= 1'b0;
	endtask : setLevel

	task automatic waitDrained(input int limit);
		for (int n = 0; n < limit && gateQ.size() != 0; n++) begin
			@(posedge clock);
		end
		cmpFlag("gate notes left", 1'b1, gateQ.size() == 0);
	endtask : waitDrained

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		logic [7:0] pct;
		supply_type sv;
		void'($urandom(32'h6C99));
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		// Overshoot discharge from a random level inside the window, interrupt masked off
		pct = 8'h6B + 8'($urandom % 23);
		gateQ.push_back(4'hC);
		gateQ.push_back(4'h0);
		setLevel(pct);
		waitDrained(100);
		cmpFlag("irq masked", 1'b0, irq);
		regRead(ADDR_STATUS, 8'h04);
		// Upper write bits are random and must be dropped; one unmapped read goes to a random high address
		regWrite(ADDR_MASK, {4'($urandom), 4'hF});
		regRead(ADDR_MASK, 8'h0F);
		regRead(4'h8 | 4'($urandom), ZERO_READ);
		// Standby dip without power saving must not boost
		supply <= 5'h1E;
		setLevel(8'h5A);
		repeat (20) @(posedge clock);
		cmpFlag("irq idle", 1'b0, irq);
		supply <= 5'h1F;
		gateQ.push_back(4'h1);
		waitDrained(20);
		cmpFlag("irq boost", 1'b1, irq);
		gateQ.push_back(4'h0);
		setLevel(8'h64);
		waitDrained(20);
		regRead(ADDR_STATUS, 8'h08);
		@(posedge clock);
		cmpFlag("irq after read", 1'b0, irq);
		// Interrupted overvoltage runs stay short of four ticks each
		supply <= 5'h1C;
		setLevel(8'h8C);
		repeat (1400) @(posedge clock);
		setLevel(8'h64);
		repeat (600) @(posedge clock);
		setLevel(8'h8C);
		repeat (1400) @(posedge clock);
		cmpFlag("early latch", 1'b0, faultLatched);
		// Overvoltage, standby undervoltage, normal undervoltage; each cleared by another supply
		for (int i = 0; i < 3; i++) begin
			sv = (i == 1) ? 5'h1E : 5'h1C;
			supply <= sv;
			gateQ.push_back(4'hA);
			if (i > 0) begin
				setLevel(8'h32);
			end
			waitDrained(2600);
			cmpFlag("fault latched", 1'b1, faultLatched);
			regRead(ADDR_STATE, (i == 0) ? 8'h04 : 8'h08);
			regRead(ADDR_STATUS, (i == 0) ? 8'h01 : 8'h02);
			setLevel(8'h78);
			repeat (30) @(posedge clock);
			setLevel(8'h64);
			gateQ.push_back(4'h0);
			supply <= sv & ~(5'h10 >> i);
			@(posedge clock);
			supply <= sv;
			waitDrained(10);
			cmpFlag("latch cleared", 1'b0, faultLatched);
		end
		print_verdict();
	end
endmodule : tb_top
